// ===== aei_regs.svh
// Register map and field constants for the ADC event interrupt block
`ifndef AEI_REGS_SVH
`define AEI_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define AEI_OFS_ENSET 12'h304
`define AEI_OFS_ENCLR 12'h308
`define AEI_OFS_EVFLAG 12'h310

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define AEI_NUM_EVENTS 22
`define AEI_BIT_STARTED 0
`define AEI_BIT_END 1
`define AEI_BIT_DONE 2
`define AEI_BIT_RESULT 3
`define AEI_BIT_CALIB 4
`define AEI_BIT_STOPPED 5
`define AEI_BIT_CH0_HIGH 6
`define AEI_BIT_CH6_LOW 19
`define AEI_BIT_CH7_HIGH 20
`define AEI_BIT_CH7_LOW 21
`define AEI_EN_RESET 22'h000000
`define AEI_FLAG_RESET 22'h000000
`define AEI_ZERO_PAD 10'h000

`endif

// ===== aei_pkg.sv
// Types for the ADC event interrupt block
package aei_pkg;
    typedef logic [21:0] aei_ev_t;

    typedef enum logic [1:0] {
        AEI_IDLE = 2'h1,
        AEI_ACK = 2'h2
    } aei_phase_e;

    typedef struct packed {
        aei_ev_t enable;
        aei_ev_t flag;
        aei_phase_e phase;
        logic [31:0] rdata;
        logic irq;
    } aei_state_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [11:0] address;
        logic [31:0] writedata;
    } aei_req_s;
endpackage

// ===== aei_event_irq.sv
// Interrupt enable set/clear registers for the ADC events
`timescale 1ns/1ps
`include "aei_regs.svh"

module aei_event_irq (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [11:0] i_address,
    input wire logic [31:0] i_writedata,
    input wire logic [21:0] i_event,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    aei_pkg::aei_state_s state;
    aei_pkg::aei_state_s next_state;
    aei_pkg::aei_req_s req;
    aei_pkg::aei_ev_t wbits;
    logic take;
    logic [31:0] en_word;
    logic [31:0] flag_word;

    assign req = '{read: i_read, write: i_write, address: i_address,
                   writedata: i_writedata};
    assign wbits = req.writedata[`AEI_NUM_EVENTS-1:0];
    assign take = (state.phase == aei_pkg::AEI_IDLE)
                  && (req.read || req.write);
    assign en_word = {`AEI_ZERO_PAD, state.enable};
    assign flag_word = {`AEI_ZERO_PAD, state.flag};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        // Events set sticky flags; set beats clear
        next_state.flag = state.flag | i_event;
        unique case (state.phase)
            aei_pkg::AEI_IDLE: begin
                if (take) begin
                    next_state.phase = aei_pkg::AEI_ACK;
                    next_state.rdata = 32'h00000000;
                    if (req.write) begin
                        unique case (req.address)
                            `AEI_OFS_ENSET: begin
                                next_state.enable |= wbits;
                            end
                            `AEI_OFS_ENCLR: begin
                                next_state.enable &= ~wbits;
                            end
                            `AEI_OFS_EVFLAG: begin
                                next_state.flag &= ~wbits | i_event;
                            end
                            default: begin
                            end
                        endcase
                    end else begin
                        unique case (req.address)
                            `AEI_OFS_ENSET, `AEI_OFS_ENCLR: begin
                                next_state.rdata = en_word;
                            end
                            `AEI_OFS_EVFLAG: begin
                                next_state.rdata = flag_word;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            aei_pkg::AEI_ACK: begin
                next_state.phase = aei_pkg::AEI_IDLE;
            end
            default: begin
                next_state.phase = aei_pkg::AEI_IDLE;
            end
        endcase
        next_state.irq = |(next_state.flag & next_state.enable);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state.enable <= `AEI_EN_RESET;
            state.flag <= `AEI_FLAG_RESET;
            state.phase <= aei_pkg::AEI_IDLE;
            state.rdata <= 32'h00000000;
            state.irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        o_readdata = state.rdata;
        o_irq = state.irq;
    end

    // Waitrequest is low only in the acknowledge cycle
    logic wait_q;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~take;
        end
    end
    assign o_waitrequest = wait_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_set_bit;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.write && req.address == `AEI_OFS_ENSET
            && wbits[`AEI_BIT_CH6_LOW])
        |=> state.enable[`AEI_BIT_CH6_LOW];
    endproperty
    a_set_bit: assert property (p_set_bit)
        else $error("set failed");

    property p_set_only;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.write && req.address == `AEI_OFS_ENSET)
        |=> (state.enable & $past(state.enable)) == $past(state.enable);
    endproperty
    a_set_only: assert property (p_set_only)
        else $error("set write cleared a bit");

    property p_set_read;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.read && req.address == `AEI_OFS_ENSET)
        |=> o_readdata[`AEI_BIT_CH7_HIGH]
                == $past(state.enable[`AEI_BIT_CH7_HIGH])
            && o_readdata[`AEI_BIT_CH7_LOW]
                == $past(state.enable[`AEI_BIT_CH7_LOW]);
    endproperty
    a_set_read: assert property (p_set_read)
        else $error("set read bad");

    property p_clr_bit;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.write && req.address == `AEI_OFS_ENCLR
            && wbits[`AEI_BIT_STARTED])
        |=> !state.enable[`AEI_BIT_STARTED];
    endproperty
    a_clr_bit: assert property (p_clr_bit)
        else $error("clear failed");

    property p_clr_only;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.write && req.address == `AEI_OFS_ENCLR)
        |=> (state.enable | $past(state.enable)) == $past(state.enable);
    endproperty
    a_clr_only: assert property (p_clr_only)
        else $error("clear write set a bit");

    property p_clr_read;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.read && req.address == `AEI_OFS_ENCLR)
        |=> o_readdata == {`AEI_ZERO_PAD, $past(state.enable)} && !o_waitrequest;
    endproperty
    a_clr_read: assert property (p_clr_read)
        else $error("clear read bad");

    property p_clr_indiv;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.write && req.address == `AEI_OFS_ENCLR)
        |=> state.enable[`AEI_BIT_CH0_HIGH:`AEI_BIT_DONE] ==
            ($past(state.enable[`AEI_BIT_CH0_HIGH:`AEI_BIT_DONE])
             & ~$past(wbits[`AEI_BIT_CH0_HIGH:`AEI_BIT_DONE]));
    endproperty
    a_clr_indiv: assert property (p_clr_indiv)
        else $error("bit clear bad");

    property p_keep;
        @(posedge i_clk) disable iff (i_reset)
        !(take && req.write) |=> $stable(state.enable);
    endproperty
    a_keep: assert property (p_keep)
        else $error("enable drifted");

    property p_zero_write;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.write && wbits == `AEI_EN_RESET)
        |=> $stable(state.enable);
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("zero write changed an enable");

    property p_irq;
        @(posedge i_clk) disable iff (i_reset)
        ##1 o_irq == |(state.flag & state.enable);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq mismatch");

    property p_irq_event;
        @(posedge i_clk) disable iff (i_reset)
        (|(i_event & state.enable)) && !(take && req.write
            && req.address == `AEI_OFS_ENCLR)
        |=> o_irq;
    endproperty
    a_irq_event: assert property (p_irq_event)
        else $error("enabled event raised no irq");

    property p_unmapped;
        @(posedge i_clk) disable iff (i_reset)
        (take && req.read && req.address != `AEI_OFS_ENSET
            && req.address != `AEI_OFS_ENCLR
            && req.address != `AEI_OFS_EVFLAG)
        |=> o_readdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_ack;
        @(posedge i_clk) disable iff (i_reset)
        take |=> !o_waitrequest ##1 o_waitrequest;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack timing bad");

    c_set: cover property (@(posedge i_clk) disable iff (i_reset)
        take && req.write && req.address == `AEI_OFS_ENSET);
    c_clr: cover property (@(posedge i_clk) disable iff (i_reset)
        take && req.write && req.address == `AEI_OFS_ENCLR);
    c_read: cover property (@(posedge i_clk) disable iff (i_reset)
        take && req.read && req.address == `AEI_OFS_ENSET);
    c_flag_clr: cover property (@(posedge i_clk) disable iff (i_reset)
        take && req.write && req.address == `AEI_OFS_EVFLAG);
    c_irq: cover property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_irq));

endmodule

// ===== tb_adc_event_irq_enable.sv
// Self-checking testbench for the ADC event interrupt enable block
`timescale 1ns/1ps
`include "aei_regs.svh"

module tb_adc_event_irq_enable;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [11:0] i_address = 12'h000;
    logic [31:0] i_writedata = 32'h00000000;
    logic [21:0] i_event = 22'h000000;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic o_irq;
    int num_errors = 0;
    int cmp_count = 0;

    aei_event_irq dut (.i_clk(i_clk), .i_reset(i_reset), .i_read(i_read),
        .i_write(i_write), .i_address(i_address),
        .i_writedata(i_writedata), .i_event(i_event),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_irq(o_irq));

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        i_read <= !wr;
        i_write <= wr;
        i_address <= a;
        i_writedata <= d;
        // Hold the request until waitrequest is seen low at a rising edge
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) chk(32'h1, 32'h0);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(q, exp);
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_irq !== exp && n < 4);
        chk({31'h0, o_irq}, {31'h0, exp});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(`AEI_OFS_ENSET, 32'h00000000);
        rd(`AEI_OFS_ENCLR, 32'h00000000);
        $display("test reset done");
    endtask

    task automatic t_set;
        wr(`AEI_OFS_ENSET, 32'h00080000);
        rd(`AEI_OFS_ENSET, 32'h00080000);
        wr(`AEI_OFS_ENSET, 32'h00300000);
        rd(`AEI_OFS_ENSET, 32'h00380000);
        wr(`AEI_OFS_ENSET, 32'h00000000);
        rd(`AEI_OFS_ENCLR, 32'h00380000);
        $display("test set done");
    endtask

    task automatic t_clear;
        logic [31:0] e;
        e = 32'h003FFFFF;
        wr(`AEI_OFS_ENSET, 32'hFFFFFFFF);
        rd(`AEI_OFS_ENCLR, e);
        for (int b = 0; b < 7; b++) begin
            wr(`AEI_OFS_ENCLR, 32'h00000001 << b);
            e[b] = 1'b0;
            rd(`AEI_OFS_ENCLR, e);
        end
        wr(`AEI_OFS_ENCLR, 32'h00000000);
        rd(`AEI_OFS_ENSET, e);
        wr(12'h000, 32'hFFFFFFFF);
        rd(12'h000, 32'h00000000);
        wr(`AEI_OFS_ENCLR, 32'h003FFFFF);
        rd(`AEI_OFS_ENSET, 32'h00000000);
        $display("test clear done");
    endtask

    task automatic t_irq;
        wr(`AEI_OFS_ENSET, 32'h00000040);
        @(posedge i_clk);
        i_event <= 22'h200040;
        @(posedge i_clk);
        i_event <= 22'h000000;
        wait_irq(1'b1);
        rd(`AEI_OFS_EVFLAG, 32'h00200040);
        wr(`AEI_OFS_ENCLR, 32'h00000040);
        wait_irq(1'b0);
        wr(`AEI_OFS_ENSET, 32'h00000040);
        wait_irq(1'b1);
        wr(`AEI_OFS_EVFLAG, 32'h00000040);
        wait_irq(1'b0);
        rd(`AEI_OFS_EVFLAG, 32'h00200000);
        $display("test irq done");
    endtask

    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(100 * 3000);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_set();
        t_clear();
        t_irq();
        final_report();
    end
endmodule
